// ==== hdl/ddr2_burst2_pkg.sv ====
// Constants for the burst-of-two DDR SRAM port model.
// Assumes a 125 MHz system clock that oversamples all pins.
`default_nettype none
package ddr2_burst2_pkg;
    // Data word and byte-lane layout, default address width
    localparam int DATA_W      = 18;
    localparam int BYTE_W      = 9;
    localparam int BYTE_N      = 2;
    localparam int ADDR_W_DEF  = 22;
    // Register map, byte addresses
    localparam int AXI_AW      = 4;
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_ZQCNT  = 4'h8;
    // Field positions
    localparam int CTRL_EN_BIT   = 0;
    localparam int ST_LOCK_BIT   = 0;
    localparam int ST_SINGLE_BIT = 1;
    localparam int ST_PLLOFF_BIT = 2;
    localparam int ST_POST_BIT   = 3;
    localparam int ST_BUSY_BIT   = 4;
    // Value after reset and AXI response codes
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Timing
    localparam int SYS_PERIOD_NS = 8;
    localparam int LOCK_TIME_US  = 20;
    localparam int LOCK_CYC      = (LOCK_TIME_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int STOP_TIME_NS  = 30;
    localparam int STOP_CYC      = (STOP_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int ZQ_PERIOD     = 1024;
    localparam int STRAP_WAIT    = 4;
    // Clock pin indices in the sampled clock vector
    localparam int CK_K  = 0;
    localparam int CK_KN = 1;
    localparam int CK_C  = 2;
    localparam int CK_CN = 3;
endpackage
`default_nettype wire

// ==== hdl/ddr2_burst2_sram_port.sv ====
// Burst-of-two DDR SRAM port with posted write, bypass and status registers.
// Assumes all pins are asynchronous to sys_clk and toggle far slower than it.
// Function
// [R1] Read command: rw high, load low, K rise
// [R2] Each command moves two 18-bit words
// [R3] Second address flips the address LSB
// [R4] Read words driven on output clock edges
// [R5] Reads may issue every K rise
// [R6] Tristate after next C rise when idle
// [R7] Write command: rw low, load low, K rise
// [R8] Write words on next K and K-bar
// [R9] Writes may issue every K rise
// [R10] Without commands, inputs are ignored
// [R11] Byte selects sampled with each word
// [R12] Active-low selects, low and high lanes
// [R13] Both C pins high at reset: single clock
// [R14] Echo clocks follow the output clocks
// [R15] Controller inserts a NOP before writes
// [R16] Last write posted until next write
// [R17] Read of posted address bypasses array
// [R18] One load strobe per bank
// [R19] Impedance update every 1024 K cycles
// [R20] PLL locks 20 us, stop resets it
// [R21] PLL off: one-cycle read latency
// [R22] PLL on: one-and-a-half cycle latency
// [R23] Outputs tristated and idle after reset
`timescale 1ns/1ps
`default_nettype none
module ddr2_burst2_sram_port
    import ddr2_burst2_pkg::*;
#(
    parameter int ADDR_W      = ADDR_W_DEF,
    parameter int STOP_CYCLES = STOP_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // AXI4-Lite slave
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Memory clocks
    input  wire logic              kClk,
    input  wire logic              kClkN,
    input  wire logic              outClk,
    input  wire logic              outClkN,
    // Memory control and data
    input  wire logic              loadStrobeN,
    input  wire logic              readWrite,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        byteWriteSelectN,
    input  wire logic              pllDisableN,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic [DATA_W-1:0]      dataOut,
    output logic                   dataOe,
    // Echo clocks and impedance update
    output logic                   echoClock,
    output logic                   echoClockN,
    output logic                   impedanceUpdate
);
    localparam int IN_W = 5 + ADDR_W + DATA_W;
    typedef enum logic [1:0] {OUT_IDLE, OUT_SECOND, OUT_TAIL} outState_t;

    logic [1:0]        rstPipe_q;
    logic              rstN;
    logic [3:0]        ckS1_q, ckS2_q, ckS3_q, ckF_q, ckRise;
    logic [IN_W-1:0]   inS1_q, inS2_q, inS3_q;
    logic              ldN, rwIn, pllOff, posOut, negOut, firstEdge, secondEdge;
    logic [1:0]        bwsN;
    logic [ADDR_W-1:0] aIn;
    logic [DATA_W-1:0] dIn;
    logic [2:0]        strapCnt_q;
    logic              strapDone_q, singleClock_q, portEnable_q;
    logic              cmdRead, cmdWrite, fetchNow, take;
    logic              rdPend_q, wrWait0_q, wrWait1_q, postValid_q, bufValid_q;
    logic [ADDR_W-1:0] rdAddr_q, cmdWrAddr_q, capAddr_q, postAddr_q;
    logic [ADDR_W-1:0] rdA [2];
    logic [ADDR_W-1:0] postA [2];
    logic [DATA_W-1:0] capW0_q, second_q, buf0_q, buf1_q;
    logic [1:0]        capBe0_q;
    logic [DATA_W-1:0] postData_q [2];
    logic [1:0]        postBe_q [2];
    logic [DATA_W-1:0] rdWord [2];
    logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
    outState_t         outState_q;
    logic [9:0]        zqCnt_q;
    logic [15:0]       zqUpdates_q;
    logic [15:0]       lockCnt_q;
    logic [7:0]        stallCnt_q;
    logic              pllLocked_q;
    logic              awHeld_q, wHeld_q;
    logic [AXI_AW-1:0] awAddr_q;
    logic [31:0]       wData_q;
    logic              wStrb0_q;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) rstPipe_q <= 2'h0;
        else rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstN = rstPipe_q[1];

    // Clock pins: three flops, filtered level, edge on agreement
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            ckS1_q <= 4'h0;
            ckS2_q <= 4'h0;
            ckS3_q <= 4'h0;
            ckF_q  <= 4'h0;
        end else begin
            ckS1_q <= {outClkN, outClk, kClkN, kClk};
            ckS2_q <= ckS1_q;
            ckS3_q <= ckS2_q;
            for (int i = 0; i < 4; i++) begin
                if (ckS2_q[i] == ckS3_q[i]) ckF_q[i] <= ckS3_q[i];
            end
        end
    end
    assign ckRise = ~(ckS2_q ^ ckS3_q) & ckS3_q & ~ckF_q;

    // Control and data pins: three flops, aligned with the clocks
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            inS1_q <= '1;
            inS2_q <= '1;
            inS3_q <= '1;
        end else begin
            inS1_q <= {loadStrobeN, readWrite, byteWriteSelectN, pllDisableN, addr, dataIn};
            inS2_q <= inS1_q;
            inS3_q <= inS2_q;
        end
    end
    assign {ldN, rwIn, bwsN, pllOff, aIn, dIn} = {inS3_q[IN_W-1:IN_W-4], ~inS3_q[IN_W-5],
                                                  inS3_q[IN_W-6:0]};

    // Strap caught once the pin samplers have filled
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            strapCnt_q    <= 3'h0;
            strapDone_q   <= 1'b0;
            singleClock_q <= 1'b0;
        end else if (!strapDone_q) begin
            strapCnt_q <= strapCnt_q + 3'h1;
            if (strapCnt_q == 3'(STRAP_WAIT)) begin
                strapDone_q   <= 1'b1;
                singleClock_q <= ckF_q[CK_C] & ckF_q[CK_CN]; // [R13]
            end
        end
    end

    // Output timing reference and latency mode
    assign posOut     = singleClock_q ? ckRise[CK_K] : ckRise[CK_C];
    assign negOut     = singleClock_q ? ckRise[CK_KN] : ckRise[CK_CN];
    assign firstEdge  = pllOff ? posOut : negOut;  // [R21] [R22]
    assign secondEdge = pllOff ? negOut : posOut;

    // Command decode, only with a load on a K rise
    assign cmdRead  = ckRise[CK_K] & ~ldN & rwIn & portEnable_q & strapDone_q;   // [R1] [R10]
    assign cmdWrite = ckRise[CK_K] & ~ldN & ~rwIn & portEnable_q & strapDone_q;  // [R7] [R10]
    assign fetchNow = ckRise[CK_K] & rdPend_q;

    // Burst addresses: LSB flipped for the second word
    assign rdA[0]   = rdAddr_q;
    assign rdA[1]   = {rdAddr_q[ADDR_W-1:1], ~rdAddr_q[0]};  // [R3]
    assign postA[0] = postAddr_q;
    assign postA[1] = {postAddr_q[ADDR_W-1:1], ~postAddr_q[0]};

    // Read words, newest posted bytes take precedence
    for (genvar w = 0; w < 2; w++) begin : g_rd
        always_comb begin
            rdWord[w] = mem[rdA[w]];
            for (int j = 0; j < 2; j++) begin
                for (int b = 0; b < BYTE_N; b++) begin
                    if (postValid_q && rdA[w] == postA[j] && postBe_q[j][b])
                        rdWord[w][b*BYTE_W +: BYTE_W] = postData_q[j][b*BYTE_W +: BYTE_W]; // [R17]
                end
            end
        end
    end

    // Read command pipeline, one burst per command
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            rdPend_q <= 1'b0;
            rdAddr_q <= '0;
        end else if (ckRise[CK_K]) begin
            rdPend_q <= cmdRead;  // [R5]
            if (cmdRead) rdAddr_q <= aIn;
        end
    end

    // Write command and data capture on K then K-bar
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            wrWait0_q   <= 1'b0;
            wrWait1_q   <= 1'b0;
            cmdWrAddr_q <= '0;
            capAddr_q   <= '0;
            capW0_q     <= '0;
            capBe0_q    <= 2'h0;
        end else begin
            if (ckRise[CK_K]) begin
                wrWait0_q <= cmdWrite;  // [R9]
                if (cmdWrite) cmdWrAddr_q <= aIn;
                if (wrWait0_q) begin
                    capAddr_q <= cmdWrAddr_q;
                    capW0_q   <= dIn;      // [R8]
                    capBe0_q  <= ~bwsN;    // [R11] [R12]
                    wrWait1_q <= 1'b1;
                end
            end else if (ckRise[CK_KN]) begin
                wrWait1_q <= 1'b0;
            end
        end
    end

    // Posted write: completed burst waits for the next write
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            postValid_q   <= 1'b0;
            postAddr_q    <= '0;
            postData_q[0] <= '0;
            postData_q[1] <= '0;
            postBe_q[0]   <= 2'h0;
            postBe_q[1]   <= 2'h0;
        end else if (ckRise[CK_KN] && wrWait1_q) begin
            postValid_q   <= 1'b1;         // [R16]
            postAddr_q    <= capAddr_q;
            postData_q[0] <= capW0_q;
            postData_q[1] <= dIn;          // [R8]
            postBe_q[0]   <= capBe0_q;
            postBe_q[1]   <= ~bwsN;        // [R11] [R12]
        end
    end

    // Array commit of the older posted burst, byte lanes masked
    always_ff @(posedge sys_clk) begin
        if (ckRise[CK_KN] && wrWait1_q && postValid_q) begin
            for (int j = 0; j < 2; j++) begin
                for (int b = 0; b < BYTE_N; b++) begin
                    if (postBe_q[j][b])
                        mem[postA[j]][b*BYTE_W +: BYTE_W] <= postData_q[j][b*BYTE_W +: BYTE_W]; // [R16] [R12]
                end
            end
        end
    end

    // Fetched burst waits here for its output edge
    assign take = (outState_q != OUT_SECOND) && firstEdge && (bufValid_q || fetchNow);
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            bufValid_q <= 1'b0;
            buf0_q     <= '0;
            buf1_q     <= '0;
        end else if (fetchNow && !(take && !bufValid_q)) begin
            bufValid_q <= 1'b1;
            buf0_q     <= rdWord[0];
            buf1_q     <= rdWord[1];
        end else if (take) begin
            bufValid_q <= 1'b0;
        end
    end

    // Output driver: two words, then release after next C rise
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            outState_q <= OUT_IDLE;
            dataOut    <= '0;
            dataOe     <= 1'b0;  // [R23]
            second_q   <= '0;
        end else begin
            case (outState_q)
                OUT_SECOND: begin
                    if (secondEdge) begin
                        dataOut    <= second_q;  // [R2] [R4]
                        outState_q <= OUT_TAIL;
                    end
                end
                OUT_IDLE, OUT_TAIL: begin
                    if (take) begin
                        dataOut    <= bufValid_q ? buf0_q : rdWord[0];  // [R4]
                        second_q   <= bufValid_q ? buf1_q : rdWord[1];
                        dataOe     <= 1'b1;
                        outState_q <= OUT_SECOND;
                    end else if (outState_q == OUT_TAIL && posOut) begin
                        dataOe     <= 1'b0;  // [R6]
                        outState_q <= OUT_IDLE;
                    end
                end
                default: outState_q <= OUT_IDLE;
            endcase
        end
    end

    // Echo clocks from the active output clock pair
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            echoClock  <= 1'b0;
            echoClockN <= 1'b0;
        end else begin
            echoClock  <= singleClock_q ? ckF_q[CK_K] : ckF_q[CK_C];   // [R14]
            echoClockN <= singleClock_q ? ckF_q[CK_KN] : ckF_q[CK_CN]; // [R14]
        end
    end

    // Periodic impedance update, counted in K cycles
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            zqCnt_q         <= 10'h0;
            zqUpdates_q     <= 16'h0;
            impedanceUpdate <= 1'b0;
        end else begin
            impedanceUpdate <= 1'b0;
            if (ckRise[CK_K]) begin
                zqCnt_q <= zqCnt_q + 10'h1;
                if (zqCnt_q == 10'(ZQ_PERIOD - 1)) begin
                    impedanceUpdate <= 1'b1;  // [R19]
                    zqUpdates_q     <= zqUpdates_q + 16'h1;
                end
            end
        end
    end

    // PLL lock tracking; a stalled K restarts the lock time
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            stallCnt_q  <= 8'h0;
            lockCnt_q   <= 16'h0;
            pllLocked_q <= 1'b0;
        end else if (pllOff) begin
            stallCnt_q  <= 8'h0;
            lockCnt_q   <= 16'h0;
            pllLocked_q <= 1'b0;
        end else if (ckRise[CK_K]) begin
            stallCnt_q <= 8'h0;
            if (lockCnt_q == 16'(LOCK_CYC - 1)) pllLocked_q <= 1'b1;  // [R20]
            else lockCnt_q <= lockCnt_q + 16'h1;
        end else if (stallCnt_q >= 8'(STOP_CYCLES)) begin
            lockCnt_q   <= 16'h0;  // [R20]
            pllLocked_q <= 1'b0;
        end else begin
            stallCnt_q <= stallCnt_q + 8'h1;
            if (lockCnt_q == 16'(LOCK_CYC - 1)) pllLocked_q <= 1'b1;
            else lockCnt_q <= lockCnt_q + 16'h1;
        end
    end

    // AXI write path: address and data in either order
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= 32'h0;
            wStrb0_q      <= 1'b0;
            portEnable_q  <= CTRL_EN_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_q      <= s_axi_awaddr;
                awHeld_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_q      <= s_axi_wdata;
                wStrb0_q     <= s_axi_wstrb[0];
                wHeld_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                if (awAddr_q == OFS_CTRL) begin
                    if (wStrb0_q) portEnable_q <= wData_q[CTRL_EN_BIT];
                end else if (awAddr_q != OFS_STATUS && awAddr_q != OFS_ZQCNT) begin
                    s_axi_bresp <= RESP_DECERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI read path: answer one cycle after the address
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0;
            case (s_axi_araddr)
                OFS_CTRL: s_axi_rdata[CTRL_EN_BIT] <= portEnable_q;
                OFS_STATUS: begin
                    s_axi_rdata[ST_LOCK_BIT]   <= pllLocked_q;
                    s_axi_rdata[ST_SINGLE_BIT] <= singleClock_q;
                    s_axi_rdata[ST_PLLOFF_BIT] <= pllOff;
                    s_axi_rdata[ST_POST_BIT]   <= postValid_q;
                    s_axi_rdata[ST_BUSY_BIT]   <= dataOe;
                end
                OFS_ZQCNT: s_axi_rdata[15:0] <= zqUpdates_q;
                default: s_axi_rresp <= RESP_DECERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks on the memory side
    a_drive_on_edge: assert property (@(posedge sys_clk) disable iff (!rstN) // [R4]
        $rose(dataOe) |-> $past(firstEdge)) else $error("drive began off the first-word edge");
    a_burst_holds: assert property (@(posedge sys_clk) disable iff (!rstN) // [R2]
        (outState_q == OUT_SECOND) |-> dataOe) else $error("bus released inside a burst");
    a_release_tail: assert property (@(posedge sys_clk) disable iff (!rstN) // [R6]
        (outState_q == OUT_TAIL && posOut && !take) |=> !dataOe) else $error("no release after C rise");
    a_second_addr: assert property (@(posedge sys_clk) disable iff (!rstN) // [R3]
        cmdRead |=> rdA[1] == {$past(aIn[ADDR_W-1:1]), ~$past(aIn[0])}) else $error("second address wrong");
    a_write_posted: assert property (@(posedge sys_clk) disable iff (!rstN) // [R16]
        (ckRise[CK_KN] && wrWait1_q) |=> postValid_q && postAddr_q == $past(capAddr_q))
        else $error("write burst not posted");
    a_zq_period: assert property (@(posedge sys_clk) disable iff (!rstN) // [R19]
        impedanceUpdate |-> $past(zqCnt_q) == 10'(ZQ_PERIOD - 1) && $past(ckRise[CK_K]))
        else $error("impedance update off period");
    a_pll_lock: assert property (@(posedge sys_clk) disable iff (!rstN) // [R20]
        $rose(pllLocked_q) |-> $past(lockCnt_q) == 16'(LOCK_CYC - 1)) else $error("lock time wrong");
    a_pll_stall: assert property (@(posedge sys_clk) disable iff (!rstN) // [R20]
        (stallCnt_q >= 8'(STOP_CYCLES) && !ckRise[CK_K]) |=> !pllLocked_q && lockCnt_q == 16'h0)
        else $error("stalled clock kept lock");
    a_cmd_ignored: assert property (@(posedge sys_clk) disable iff (!rstN) // [R10]
        (ckRise[CK_K] && ldN) |=> !rdPend_q && !wrWait0_q) else $error("command taken without load");
endmodule
`default_nettype wire

// ==== test/mem_ctrl_model.sv ====
// Memory controller model: free-running K and C pairs, queued commands.
// Assumes the bench pushes {load, read, addr, mask0, word0, mask1, word1} into cmdQ.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
    // Clocks
    output logic        kClk,
    output logic        kClkN,
    output logic        outClk,
    output logic        outClkN,
    // Command and data
    output logic        loadStrobeN,
    output logic        readWrite,
    output logic [7:0]  addr,
    output logic [1:0]  byteWriteSelectN,
    output logic [17:0] dataIn
);
    logic [49:0] cmdQ[$];
    logic [49:0] cur;
    logic [49:0] prev;
    int          kCount;

    // Output clocks copy the input pair, so the strap stays in two-clock mode
    assign outClk  = kClk;
    assign outClkN = kClkN;

    // Pins change a quarter period away from any clock edge
    initial begin
        {kClk, kClkN, loadStrobeN, readWrite, addr, byteWriteSelectN, dataIn} = {2'b01, 2'b11, 8'h00, 2'b11, 18'h0};
        cur = '0;
        prev = '0;
        kCount = 0;
        #3;
        forever begin
            #20 {kClk, kClkN} = 2'b10;
            kCount++;
            #20 if (prev[49:48] == 2'b10) {byteWriteSelectN, dataIn} = prev[19:0];
            else {byteWriteSelectN, dataIn} = {2'b11, ~dataIn};
            #20 {kClk, kClkN} = 2'b01;
            #20 prev = cur;
            cur = (cmdQ.size() > 0) ? cmdQ.pop_front() : 50'h0;
            if (prev[49:48] == 2'b10) {byteWriteSelectN, dataIn} = prev[39:20];
            else {byteWriteSelectN, dataIn} = {2'b11, ~dataIn};
            {loadStrobeN, readWrite, addr} = {~cur[49], cur[48:40]};
        end
    end
endmodule
`default_nettype wire

// ==== test/ddr2_burst2_sram_port_tb.sv ====
// Bench for the burst-of-two SRAM port: random bursts, byte masks, registers.
// Assumes the controller model drives every link pin except pllDisableN, which the bench drives.
`timescale 1ns/1ps
`default_nettype none
module ddr2_burst2_sram_port_tb;
    import ddr2_burst2_pkg::*;
    logic        sys_clk, resetn, pllDisableN, awV, wV, bR, arV, rR, prevOe;
    logic [3:0]  awA, arA;
    logic [31:0] wD;
    logic [17:0] mem[0:7], expQ[$], prevOut;
    logic [2:0]  a;
    wire         awRdy, wRdy, bV, arRdy, rV, kClk, kClkN, outClk, outClkN, ldN, rw, dataOe, impUpd, echo, echoN;
    wire  [1:0]  bResp, rResp, bwsN;
    wire  [31:0] rD;
    wire  [7:0]  addr;
    wire  [17:0] dataIn, dataOut;
    int          seed, i, pass, zqN, lastK, cyc, miscompares, compares;

    ddr2_burst2_sram_port #(.ADDR_W(8), .STOP_CYCLES(16)) ddr2_burst2_sram_port_inst (.sys_clk(sys_clk),
        .resetn(resetn), .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
        .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR), .kClk(kClk), .kClkN(kClkN), .outClk(outClk),
        .outClkN(outClkN), .loadStrobeN(ldN), .readWrite(rw), .addr(addr), .byteWriteSelectN(bwsN),
        .pllDisableN(pllDisableN), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .echoClock(echo),
        .echoClockN(echoN), .impedanceUpdate(impUpd));
    mem_ctrl_model mem_ctrl_model_inst (.kClk(kClk), .kClkN(kClkN), .outClk(outClk), .outClkN(outClkN),
        .loadStrobeN(ldN), .readWrite(rw), .addr(addr), .byteWriteSelectN(bwsN), .dataIn(dataIn));

    task automatic check(input logic [31:0] seen, exp, input string what);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic axiWr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        {awA, wD, awV, wV, bR} <= {ad, d, 3'b111};
        do begin
            @(posedge sys_clk);
            if (awRdy) awV <= 1'b0;
            if (wRdy) wV <= 1'b0;
        end while (bV !== 1'b1);
        check(bResp, er, "bresp");
        bR <= 1'b0;
    endtask
    task automatic axiRd(input logic [3:0] ad, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        {arA, arV, rR} <= {ad, 2'b11};
        do begin
            @(posedge sys_clk);
            if (arRdy) arV <= 1'b0;
        end while (rV !== 1'b1);
        check(rD, ed, "rdata");
        check(rResp, er, "rresp");
        rR <= 1'b0;
    endtask
    function automatic logic [17:0] merge(input logic [17:0] o, d, input logic [1:0] m);
        return {m[1] ? o[17:9] : d[17:9], m[0] ? o[8:0] : d[8:0]};
    endfunction
    task automatic wrCmd(input logic [2:0] ad, input logic [1:0] m0, m1);
        logic [17:0] d0, d1;
        d0 = 18'($random(seed));
        d1 = 18'($random(seed));
        mem_ctrl_model_inst.cmdQ.push_back({2'b10, 5'h0, ad, m0, d0, m1, d1});
        mem[ad] = merge(mem[ad], d0, m0);
        mem[ad ^ 3'h1] = merge(mem[ad ^ 3'h1], d1, m1);
    endtask
    task automatic rdCmd(input logic [2:0] ad);
        mem_ctrl_model_inst.cmdQ.push_back({2'b11, 5'h0, ad, 40'h0});
        expQ.push_back(mem[ad]);
        expQ.push_back(mem[ad ^ 3'h1]);
    endtask
    task automatic idle;
        wait (mem_ctrl_model_inst.cmdQ.size() == 0);
        repeat (60) @(posedge sys_clk);
    endtask

    // System clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Each new word on the data pins is compared with the oldest note
    always @(posedge sys_clk) begin
        if (dataOe === 1'b1 && (prevOe !== 1'b1 || dataOut !== prevOut)) check(dataOut, expQ.pop_front(), "word");
        prevOe <= dataOe;
        prevOut <= dataOut;
        cyc++;
        if (cyc == 50000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // Impedance update spacing in K cycles
    always @(posedge impUpd) begin
        if (zqN > 0) check(mem_ctrl_model_inst.kCount - lastK, ZQ_PERIOD, "zq period");
        lastK = mem_ctrl_model_inst.kCount;
        zqN++;
    end
    // Echo pair lags its clocks under half a period
    always @(posedge outClk) if (cyc > 40) check({echo, echoN}, 2'b01, "echo");
    always @(posedge outClkN) if (cyc > 40) check({echo, echoN}, 2'b10, "echo");
    // Main sequence
    initial begin
        {seed, zqN, cyc, miscompares, compares} = {32'h5677bb9b, 128'h0};
        {resetn, pllDisableN, awV, wV, bR, arV, rR, awA, arA, wD} = {2'b01, 5'h0, 40'h0};
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check(dataOe, 0, "dataOe");
        axiRd(OFS_CTRL, 32'h1, RESP_OKAY);
        axiRd(4'hC, 32'h0, RESP_DECERR);
        axiWr(4'hC, 32'h0, RESP_DECERR);
        $display("test registers done");
        for (pass = 0; pass < 2; pass++) begin
            pllDisableN <= (pass == 0);
            for (i = 0; i < 8; i += 2) wrCmd(3'(i), 2'h0, 2'h0);
            for (i = 0; i < 12; i++) begin
                a = 3'($random(seed));
                wrCmd(a, 2'($random(seed)), 2'($random(seed)));
                rdCmd(a ^ 3'($random(seed) & 1));
                rdCmd(a + 3'h2);
                mem_ctrl_model_inst.cmdQ.push_back(50'h0);
            end
            idle();
            $display("test bursts pass %0d done", pass);
        end
        pllDisableN <= 1'b1;
        // Disabled port must ignore a write
        axiWr(OFS_CTRL, 32'h0, RESP_OKAY);
        mem_ctrl_model_inst.cmdQ.push_back({2'b10, 48'h0});
        idle();
        axiWr(OFS_CTRL, 32'h1, RESP_OKAY);
        rdCmd(3'h0);
        idle();
        wait (zqN >= 3);
        repeat (20) @(posedge sys_clk);
        axiRd(OFS_ZQCNT, zqN, RESP_OKAY);
        axiRd(OFS_STATUS, (1 << ST_LOCK_BIT) | (1 << ST_POST_BIT), RESP_OKAY);
        check(expQ.size(), 0, "pending words");
        $display("test disable and impedance done");
        report_and_stop();
    end
endmodule
`default_nettype wire
